// ### core/shifter_pkg.sv
// Shared constants and carrier types for the eight-bit rotating shifter
`default_nettype none
package shifter_pkg;
   localparam int DATA_W = 8;
   localparam int AMT_W = 3;
   localparam int BUF_DEPTH = 2;
   localparam int SYNC_STAGES = 2;
   // Values after reset
   localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
   localparam logic [DATA_W-1:0] DRIVE_RST = 8'h00;
   localparam logic OE_RST = 1'b0;
   // Synchroniser reset levels: outputs released, inversion off, latch closed
   localparam logic [SYNC_STAGES-1:0] OEN_SYNC_RST = 2'h3;
   localparam logic [SYNC_STAGES-1:0] INV_SYNC_RST = 2'h0;
   localparam logic [SYNC_STAGES-1:0] OPEN_SYNC_RST = 2'h0;
   localparam logic [AMT_W-1:0] AMT_NONE = 3'h0;
   localparam logic [AMT_W-1:0] AMT_ONE = 3'h1;

   // One shift request: word and rotate count travel together
   typedef struct packed {
      logic [AMT_W-1:0] shift_amount;
      logic [DATA_W-1:0] data;
   } shift_req_s;

   // Output pin group
   typedef struct packed {
      logic [DATA_W-1:0] result;
      logic result_oe;
   } pin_out_s;
endpackage
`default_nettype wire

// ### core/pair_buffer.sv
// Two-entry valid/ready buffer for the shifter's request path
`default_nettype none
module pair_buffer #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // Elaboration check: the one-bit pointers only serve two entries
   if (DEPTH != 2 || WIDTH < 1)
   begin : g_bad_params
      $error("pair_buffer serves exactly two entries of positive width");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [1:0] count_q, count_d;
   logic push, pop;

   // Handshakes: full and empty come straight from the fill count
   assign in_ready = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next pointers, count and storage
   always_comb
   begin
      mem_d = mem_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d = count_q;
      if (push)
      begin
         mem_d[wr_ptr_q] = in_data;
         wr_ptr_d = ~wr_ptr_q;
      end
      if (pop)
         rd_ptr_d = ~rd_ptr_q;
      if (push && !pop)
         count_d = count_q + 2'h1;
      else if (pop && !push)
         count_d = count_q - 2'h1;
   end

   // Register stage
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         mem_q <= '{default: '0};
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end
      else
      begin
         mem_q <= mem_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
      end
   end

   AST_NO_OVERFLOW: assert property (@(posedge clock) disable iff (!rstn)
      !in_ready && !out_ready |=> !in_ready && $stable(out_data))
      else $error("full buffer lost its head word");
endmodule
`default_nettype wire

// ### core/rotate_shifter.sv
// Eight-bit rotate-right shifter with output latch, inversion and one output enable
//
// Operation
// - The word is shifted toward the low end by the 1 to 7 places given as a binary count on shift_amount.
// - A shift_amount of zero passes the word unchanged, so data_in_msb lands on result_msb.
// - The eight result bits sit in a clocked register that loads each buffered word on a clock edge while open and holds while closed.
// - With invert_outputs high all result bits are complemented together, otherwise they are true.
// - With output_enable_n high all eight result pins are released, with it low they are driven.
`default_nettype none
module rotate_shifter
   import shifter_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Request stream
   input wire logic req_valid,
   output logic req_ready,
   input wire shifter_pkg::shift_req_s req,
   // Control pins, asynchronous to clock
   input wire logic latch_open,
   input wire logic invert_outputs,
   input wire logic output_enable_n,
   // Result pins
   output shifter_pkg::pin_out_s pins
);
   import shifter_pkg::*;

   // Rotate right: the doubled word makes vacated bits refill from the top
   function automatic logic [DATA_W-1:0] rotr(
      input logic [DATA_W-1:0] d,
      input logic [AMT_W-1:0] n
   );
      logic [2*DATA_W-1:0] t;
      t = {d, d} >> n;
      return t[DATA_W-1:0];
   endfunction

   // Buffered request stream
   logic head_valid;
   logic head_ready;
   shift_req_s head;

   pair_buffer #(
      .WIDTH($bits(shift_req_s)),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clock(clock),
      .rstn(rstn),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(req),
      .out_valid(head_valid),
      .out_ready(head_ready),
      .out_data(head)
   );

   // Pin synchronisers: only the second stage is read by logic
   logic [SYNC_STAGES-1:0] oen_sync_q, oen_sync_d;
   logic [SYNC_STAGES-1:0] inv_sync_q, inv_sync_d;
   logic [SYNC_STAGES-1:0] open_sync_q, open_sync_d;
   logic oen_s, inv_s, open_s;

   always_comb
   begin
      oen_sync_d = {oen_sync_q[0], output_enable_n};
      inv_sync_d = {inv_sync_q[0], invert_outputs};
      open_sync_d = {open_sync_q[0], latch_open};
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         oen_sync_q <= OEN_SYNC_RST;
         inv_sync_q <= INV_SYNC_RST;
         open_sync_q <= OPEN_SYNC_RST;
      end
      else
      begin
         oen_sync_q <= oen_sync_d;
         inv_sync_q <= inv_sync_d;
         open_sync_q <= open_sync_d;
      end
   end

   assign oen_s = oen_sync_q[1];
   assign inv_s = inv_sync_q[1];
   assign open_s = open_sync_q[1];

   // A closed latch refuses words; the buffer then fills and stalls the source
   assign head_ready = open_s;
   logic pop;
   assign pop = head_valid && head_ready;

   // Latch stage: takes each rotated word while open, holds while closed
   logic [DATA_W-1:0] latch_q, latch_d;

   always_comb
   begin
      latch_d = latch_q;
      if (pop)
         latch_d = rotr(head.data, head.shift_amount);
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         latch_q <= LATCH_RST;
      else
         latch_q <= latch_d;
   end

   // Output stage: polarity and drive are registered so pins never glitch
   logic [DATA_W-1:0] drive_q, drive_d;
   logic oe_q, oe_d;

   always_comb
   begin
      drive_d = inv_s ? ~latch_q : latch_q;
      oe_d = ~oen_s;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         drive_q <= DRIVE_RST;
         oe_q <= OE_RST;
      end
      else
      begin
         drive_q <= drive_d;
         oe_q <= oe_d;
      end
   end

   // One enable for all eight pins; the bench checks result_oe, no wire level is modelled
   assign pins = '{result: drive_q, result_oe: oe_q};

   AST_ROTATE: assert property (
      @(posedge clock) disable iff (!rstn)
      pop |=> latch_q == rotr($past(head.data), $past(head.shift_amount)))
      else $error("latch does not hold the rotated word");

   AST_SHIFT_ONE: assert property (
      @(posedge clock) disable iff (!rstn)
      pop && head.shift_amount == AMT_ONE |=>
         latch_q[DATA_W-2:0] == $past(head.data[DATA_W-1:1]))
      else $error("shift by one misplaces bits");

   AST_PASS_ZERO: assert property (
      @(posedge clock) disable iff (!rstn)
      pop && head.shift_amount == AMT_NONE |=> latch_q == $past(head.data))
      else $error("zero shift alters the word");

   AST_HOLD_CLOSED: assert property (
      @(posedge clock) disable iff (!rstn)
      !open_s |=> $stable(latch_q))
      else $error("closed latch changed");

   AST_STALL_CLOSED: assert property (
      @(posedge clock) disable iff (!rstn)
      !open_s && head_valid |=> head_valid && $stable(head))
      else $error("closed latch dropped a buffered word");

   AST_INVERT_ON: assert property (
      @(posedge clock) disable iff (!rstn)
      inv_s |=> drive_q == ~$past(latch_q))
      else $error("inverted result wrong");

   AST_INVERT_OFF: assert property (
      @(posedge clock) disable iff (!rstn)
      !inv_s |=> drive_q == $past(latch_q))
      else $error("true result wrong");

   // Raw pin held three edges reaches the pins; rstn is in the window
   // because the edge that releases reset loads nothing into the syncs
   AST_RELEASE: assert property (
      @(posedge clock) disable iff (!rstn)
      (rstn && output_enable_n) [*3] |=> !pins.result_oe)
      else $error("pins driven while disabled");

   AST_DRIVE: assert property (
      @(posedge clock) disable iff (!rstn)
      (rstn && !output_enable_n) [*3] |=> pins.result_oe)
      else $error("pins released while enabled");

   // Pins stay released on the first edge after reset is let go
   AST_RESET_OFF: assert property (
      @(posedge clock) disable iff (!rstn)
      !$past(rstn) |-> !pins.result_oe)
      else $error("pins driven straight out of reset");

   // Low result bit comes from the input bit picked by the count
   AST_LOW_BIT: assert property (
      @(posedge clock) disable iff (!rstn)
      pop |=> latch_q[0] == $past(head.data[head.shift_amount]))
      else $error("low result bit taken from the wrong input bit");

   // The bit that leaves the low end re-enters at the top
   AST_WRAP_ONE: assert property (
      @(posedge clock) disable iff (!rstn)
      pop && head.shift_amount == AMT_ONE |=>
         latch_q[DATA_W-1] == $past(head.data[0]))
      else $error("wrapped bit missing at the top");

   // Inversion pin held three edges complements every pin together
   AST_PIN_INVERT: assert property (
      @(posedge clock) disable iff (!rstn)
      (rstn && invert_outputs) [*3] |=> pins.result == ~$past(latch_q))
      else $error("pins not complemented while inversion held");

   // Inversion pin low for three edges gives the true latch value
   AST_PIN_TRUE: assert property (
      @(posedge clock) disable iff (!rstn)
      (rstn && !invert_outputs) [*3] |=> pins.result == $past(latch_q))
      else $error("pins not true while inversion off");

   // Latch pin low for three edges freezes the held word
   AST_PIN_CLOSED: assert property (
      @(posedge clock) disable iff (!rstn)
      (rstn && !latch_open) [*3] |=> $stable(latch_q))
      else $error("latch moved while its pin was closed");
endmodule
`default_nettype wire

// ### dv/req_source.sv
// Request source model that offers shift words to the shifter
`default_nettype none
module req_source
   import shifter_pkg::*;
(
   // Clock
   input wire logic clock,
   // Request stream
   output var logic req_valid,
   input wire logic req_ready,
   output var shifter_pkg::shift_req_s req
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle stream at time zero
   initial
   begin
      req_valid = 1'b0;
      req = '0;
   end
   // Offer one word and hold it until taken; ready is read mid-cycle
   // because it only moves on the rising edge
   task automatic send(input logic [DATA_W-1:0] d,
                       input logic [AMT_W-1:0] a);
      logic taken;
      @(posedge clock);
      req_valid <= 1'b1;
      req <= {a, d};
      do
      begin
         @(negedge clock);
         taken = req_ready;
         @(posedge clock);
      end
      while (taken !== 1'b1);
      req_valid <= 1'b0;
      req <= ~{a, d};  // Released bus must not look like the last word
   endtask
endmodule
`default_nettype wire

// ### dv/eight_bit_barrel_shifter_test.sv
// Self-checking bench for the rotating shifter
`default_nettype none
module eight_bit_barrel_shifter_test;
   import shifter_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rstn, req_valid, req_ready;
   logic latch_open, invert_outputs, output_enable_n;
   shift_req_s req;
   pin_out_s pins;
   int fails, checks, cycles;
   // Clock at 20 MHz
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   rotate_shifter DUT (.clock(clock), .rstn(rstn), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .latch_open(latch_open),
      .invert_outputs(invert_outputs), .output_enable_n(output_enable_n),
      .pins(pins));
   req_source src (.clock(clock), .req_valid(req_valid),
      .req_ready(req_ready), .req(req));
   function automatic logic [DATA_W-1:0] rotr(input logic [DATA_W-1:0] d,
                                              input int n);
      return (d >> n) | (d << (DATA_W - n));
   endfunction
   task automatic check(input logic [DATA_W-1:0] seen, exp, input string m);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   // Ends on a falling edge so that outputs are read settled
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   // Pins cross a two-stage sync, so allow four edges to settle
   task automatic set_pins(input logic o, i, e);
      @(posedge clock);
      latch_open <= o;
      invert_outputs <= i;
      output_enable_n <= e;
      wait_cycles(4);
   endtask
   task automatic t_rotate();
      for (int n = 0; n < 8; n++)
      begin
         src.send(8'hC1 + 8'(n), 3'(n));
         wait_cycles(5);
         check(pins.result, rotr(8'hC1 + 8'(n), n), "rotate");
      end
   endtask
   task automatic t_invert();
      set_pins(1'b1, 1'b1, 1'b0);
      src.send(8'h3C, 3'h2);
      wait_cycles(5);
      check(pins.result, ~rotr(8'h3C, 2), "inverted");
      set_pins(1'b1, 1'b0, 1'b0);
      check(pins.result, rotr(8'h3C, 2), "true");
   endtask
   // Closed latch holds and back-pressures; two words fill the buffer
   task automatic t_hold();
      set_pins(1'b0, 1'b0, 1'b0);
      src.send(8'h5A, 3'h1);
      src.send(8'hE7, 3'h7);
      @(negedge clock);
      check({7'h00, req_ready}, 8'h00, "buffer full");
      check(pins.result, rotr(8'h3C, 2), "held");
      set_pins(1'b1, 1'b0, 1'b0);
      wait_cycles(4);
      check(pins.result, rotr(8'hE7, 7), "drained");
   endtask
   task automatic t_release();
      set_pins(1'b1, 1'b0, 1'b1);
      check({7'h00, pins.result_oe}, 8'h00, "released");
      set_pins(1'b1, 1'b0, 1'b0);
      check({7'h00, pins.result_oe}, 8'h01, "driven");
   endtask
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Hang guard well above the hundred or so cycles the run needs
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fails++;
         end_of_test();
      end
   end
   initial
   begin
      rstn = 1'b0;
      latch_open = 1'b1;
      invert_outputs = 1'b0;
      output_enable_n = 1'b0;
      fails = 0;
      checks = 0;
      cycles = 0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      wait_cycles(1);
      check(pins.result, DRIVE_RST, "reset value");
      wait_cycles(4);
      t_rotate();
      t_invert();
      t_hold();
      t_release();
      end_of_test();
   end
endmodule
`default_nettype wire
